// *** cpfl_controller.sv ***
// Fast-lock sequencer that sets the charge pump state and current scale
`timescale 1ns/100ps
`default_nettype none
module cpfl_controller
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Detector inputs, asynchronous
    input wire logic reference_detector_input,
    input wire logic feedback_detector_input,
    // Comparator decisions, same clock
    input wire logic comparator_up,
    input wire logic comparator_down,
    // Configuration
    input wire logic pump_polarity_select,
    input wire logic current_offset_enable,
    input wire logic [1:0] fdet_scale_select,
    input wire logic [2:0] wide_scale_select,
    input wire logic [1:0] final_scale_select,
    // Fast-detect pump output
    output logic fdet_source,
    output logic fdet_sink,
    output logic [5:0] fdet_scale,
    // Closed-loop pump output
    output logic loop_source,
    output logic loop_sink,
    output logic [3:0] loop_scale,
    // Status
    output cpfl_pkg::cpfl_state_type pump_state,
    output logic freq_locked,
    output logic comparison_tick
);
    import cpfl_pkg::*;
    logic [2:0] div_count;
    logic [2:0] next_div_count;
    logic [4:0] win_count;
    logic [4:0] next_win_count;
    logic window_end;
    logic [7:0] ref_count;
    logic [7:0] fb_count;
    logic [7:0] diff;
    logic [1:0] err_sign;
    logic [1:0] next_err_sign;
    logic next_freq_locked;
    logic [3:0] near_run;
    logic [3:0] next_near_run;
    cpfl_state_type next_pump_state;
    logic next_fdet_source;
    logic next_fdet_sink;
    logic [5:0] next_fdet_scale;
    logic next_loop_source;
    logic next_loop_sink;
    logic [3:0] next_loop_scale;
    logic drive_up;
    logic drive_down;

    // Divide-by-eight comparison tick and 19-tick window
    always_comb
    begin
        next_div_count = div_count + 3'h1;
        next_win_count = win_count;
        if (comparison_tick)
        begin
            next_win_count = (win_count == WIN_LAST) ? 5'h00 : win_count + 5'h01;
        end
    end
    assign comparison_tick = (div_count == DIV_LAST);
    assign window_end = comparison_tick && (win_count == WIN_LAST);

    cpfl_edge_counter u_ref_counter
    (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .sig_in(reference_detector_input),
        .clear(window_end),
        .count(ref_count),
        .edge_seen()
    );

    cpfl_edge_counter u_fb_counter
    (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .sig_in(feedback_detector_input),
        .clear(window_end),
        .count(fb_count),
        .edge_seen()
    );

    assign diff = (ref_count >= fb_count) ? ref_count - fb_count : fb_count - ref_count;

    // Frequency verdict at each window end, plus a phase-lock run counter
    always_comb
    begin
        next_freq_locked = freq_locked;
        next_err_sign = err_sign;
        next_near_run = near_run;
        if (window_end)
        begin
            next_freq_locked = (diff <= LOCK_TOL);
            if (fb_count < ref_count)
            begin
                next_err_sign = SIGN_SLOWER;
            end
            else if (fb_count > ref_count)
            begin
                next_err_sign = SIGN_FASTER;
            end
            else
            begin
                next_err_sign = SIGN_EQUAL;
            end
            if (diff > NEAR_TOL || pump_state != CPFL_WIDE)
            begin
                next_near_run = 4'h0;
            end
            else if (near_run != PHASE_LOCK_COUNT)
            begin
                next_near_run = near_run + 4'h1;
            end
        end
    end

    // State sequencing
    always_comb
    begin
        next_pump_state = pump_state;
        case (pump_state)
            CPFL_FDET:
            begin
                if (window_end && next_freq_locked)
                begin
                    if (wide_scale_select == 3'h0)
                    begin
                        next_pump_state = CPFL_FINAL;
                    end
                    else
                    begin
                        next_pump_state = CPFL_WIDE;
                    end
                end
            end
            CPFL_WIDE:
            begin
                if (window_end && !next_freq_locked)
                begin
                    next_pump_state = CPFL_FDET;
                end
                else if (near_run == PHASE_LOCK_COUNT)
                begin
                    next_pump_state = CPFL_FINAL;
                end
            end
            CPFL_FINAL:
            begin
                if (window_end && !next_freq_locked)
                begin
                    next_pump_state = CPFL_FDET;
                end
            end
            default:
            begin
                next_pump_state = CPFL_FDET;
            end
        endcase
    end

    // Drive directions: polarity 0 pulls node down when feedback is fast
    always_comb
    begin
        drive_up = (err_sign == SIGN_SLOWER) ^ pump_polarity_select;
        drive_down = (err_sign == SIGN_FASTER) ^ pump_polarity_select;
        if (err_sign == SIGN_EQUAL)
        begin
            drive_up = 1'b0;
            drive_down = 1'b0;
        end
        next_fdet_source = 1'b0;
        next_fdet_sink = 1'b0;
        next_loop_source = 1'b0;
        next_loop_sink = 1'b0;
        next_fdet_scale = 6'h00;
        next_loop_scale = 4'h0;
        if (next_pump_state == CPFL_FDET)
        begin
            next_fdet_source = drive_up;
            next_fdet_sink = drive_down;
            next_fdet_scale = 6'(FDET_STEP * fdet_scale_select);
        end
        else
        begin
            next_loop_source = comparator_up ^ pump_polarity_select & (comparator_up ^ comparator_down);
            next_loop_sink = comparator_down ^ pump_polarity_select & (comparator_up ^ comparator_down);
            if (next_pump_state == CPFL_WIDE)
            begin
                next_loop_scale = {wide_scale_select, 1'b0};
            end
            else
            begin
                next_loop_scale = {2'h0, final_scale_select} + 4'h1
                    + (current_offset_enable ? OFFSET_ADD : 4'h0);
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            div_count <= 3'h0;
            win_count <= 5'h00;
            freq_locked <= 1'b0;
            err_sign <= SIGN_EQUAL;
            near_run <= 4'h0;
            pump_state <= CPFL_FDET;
            fdet_source <= 1'b0;
            fdet_sink <= 1'b0;
            fdet_scale <= 6'h00;
            loop_source <= 1'b0;
            loop_sink <= 1'b0;
            loop_scale <= 4'h0;
        end
        else
        begin
            div_count <= next_div_count;
            win_count <= next_win_count;
            freq_locked <= next_freq_locked;
            err_sign <= next_err_sign;
            near_run <= next_near_run;
            pump_state <= next_pump_state;
            fdet_source <= next_fdet_source;
            fdet_sink <= next_fdet_sink;
            fdet_scale <= next_fdet_scale;
            loop_source <= next_loop_source;
            loop_sink <= next_loop_sink;
            loop_scale <= next_loop_scale;
        end
    end

    sequence tick_gap_s;
        !comparison_tick [*7] ##1 comparison_tick;
    endsequence

    one_state_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        $onehot(pump_state)) else $error("pump state not one-hot");
    window_len_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        window_end |=> !window_end [*8]) else $error("window too short");
    tick_rate_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        comparison_tick |=> tick_gap_s) else $error("tick not every eighth cycle");
    fdet_isolated_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        pump_state == CPFL_FDET |-> !loop_source && !loop_sink && loop_scale == 4'h0)
        else $error("closed-loop path active in detect");
    loop_isolated_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        pump_state != CPFL_FDET |-> !fdet_source && !fdet_sink && fdet_scale == 6'h00)
        else $error("detect path active in closed loop");
    loop_follow_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        ##1 (pump_state != CPFL_FDET && $past(comparator_up) && !$past(comparator_down)
        && !$past(pump_polarity_select)) |-> loop_source && !loop_sink)
        else $error("closed loop ignores comparator");
    skip_wide_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (pump_state == CPFL_FDET && wide_scale_select == 3'h0) |=> pump_state != CPFL_WIDE)
        else $error("wide state entered with zero current");
    wide_scale_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        ##1 (pump_state == CPFL_WIDE) |-> loop_scale == {$past(wide_scale_select), 1'b0})
        else $error("wide scale wrong");
    final_scale_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        ##1 (pump_state == CPFL_FINAL) |-> loop_scale == {2'h0, $past(final_scale_select)}
        + 4'h1 + ($past(current_offset_enable) ? OFFSET_ADD : 4'h0))
        else $error("final scale wrong");
    fdet_scale_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        ##1 (pump_state == CPFL_FDET) |-> fdet_scale == 6'(FDET_STEP * $past(fdet_scale_select)))
        else $error("detect scale wrong");
    to_final_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (pump_state == CPFL_WIDE && near_run == PHASE_LOCK_COUNT && !window_end)
        |=> pump_state == CPFL_FINAL) else $error("phase lock ignored");
    relock_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (window_end && diff > LOCK_TOL) |=> pump_state == CPFL_FDET && !freq_locked)
        else $error("large error did not return to detect");
endmodule : cpfl_controller
`default_nettype wire

// *** cpfl_pkg.sv ***
// Constants and types for the charge pump fast-lock sequencer
package cpfl_pkg;
    localparam int CMP_DIVIDE = 8;
    localparam int WINDOW_CMP_CYCLES = 19;
    localparam int WINDOW_CORE_CYCLES = WINDOW_CMP_CYCLES * CMP_DIVIDE;
    localparam logic [2:0] DIV_LAST = 3'h7;
    localparam logic [4:0] WIN_LAST = 5'h12;
    localparam logic [7:0] EDGE_MAX = 8'hff;
    localparam logic [7:0] LOCK_TOL = 8'h01;
    localparam logic [7:0] NEAR_TOL = 8'h00;
    localparam logic [3:0] OFFSET_ADD = 4'h4;
    localparam logic [5:0] FDET_STEP = 6'h14;
    localparam logic [3:0] PHASE_LOCK_COUNT = 4'h8;
    localparam logic [1:0] SIGN_SLOWER = 2'h1;
    localparam logic [1:0] SIGN_FASTER = 2'h2;
    localparam logic [1:0] SIGN_EQUAL = 2'h0;

    typedef enum logic [2:0] {
        CPFL_FDET = 3'b001,
        CPFL_WIDE = 3'b010,
        CPFL_FINAL = 3'b100
    } cpfl_state_type;
endpackage : cpfl_pkg

// *** cpfl_edge_counter.sv ***
// Synchronised rising-edge counter for one detector input
`timescale 1ns/100ps
`default_nettype none
module cpfl_edge_counter
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Asynchronous detector input
    input wire logic sig_in,
    // Window control
    input wire logic clear,
    // Count result
    output logic [7:0] count,
    output logic edge_seen
);
    import cpfl_pkg::*;
    logic meta;
    logic sync;
    logic prev;
    logic [7:0] next_count;

    assign edge_seen = sync & ~prev;

    always_comb
    begin
        next_count = count;
        if (clear)
        begin
            next_count = {7'h00, edge_seen};
        end
        else if (edge_seen && count != EDGE_MAX)
        begin
            next_count = count + 8'h01;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta <= 1'b0;
            sync <= 1'b0;
            prev <= 1'b0;
            count <= 8'h00;
        end
        else
        begin
            meta <= sig_in;
            sync <= meta;
            prev <= sync;
            count <= next_count;
        end
    end
endmodule : cpfl_edge_counter
`default_nettype wire

// *** cpfl_vco_model.sv ***
// Behavioural oscillator that slews toward a target and drives the feedback input
`timescale 1ns/100ps
`default_nettype none
module cpfl_vco_model
(
    // Frequency the loop settles toward, as a half period in ns
    input wire logic [7:0] target_half,
    // Divided oscillator output
    output logic fb_out
);
    int half = 60;

    initial
    begin
        fb_out = 1'b0;
        #7;
        forever
        begin
            #(half) fb_out = ~fb_out;
            // Slew held to one ns per cycle so the lock range is never overshot
            if (fb_out && half != int'(target_half))
                half = (half < int'(target_half)) ? half + 1 : half - 1;
        end
    end
endmodule : cpfl_vco_model
`default_nettype wire

// *** tb_top.sv ***
// Self-checking testbench for the charge pump fast-lock sequencer
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import cpfl_pkg::*;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic ref_in = 1'b0;
    logic fb_in, up = 1'b0, down = 1'b0, pol = 1'b0, offs = 1'b0;
    logic [1:0] fsel = 2'h1;
    logic [2:0] wsel = 3'h3;
    logic [1:0] lsel = 2'h0;
    logic [7:0] target = 8'h3c;
    logic fdet_source, fdet_sink, loop_source, loop_sink, freq_locked, comparison_tick;
    logic [5:0] fdet_scale;
    logic [3:0] loop_scale;
    cpfl_state_type pump_state;
    logic [2:0] seen;
    logic [1:0] ref_div = 2'h0;
    int failures = 0;
    int n_checks = 0;
    int cyc = 0;
    int ticks, t_wide;

    always #10 ref_clk = ~ref_clk;
    always @(posedge ref_clk) cyc <= cyc + 1;
    // Reference input with an 80 ns period, moved off the sampling edge
    always @(negedge ref_clk)
    begin
        ref_div <= ref_div + 2'h1;
        if (ref_div[0])
            ref_in <= ~ref_in;
    end

    cpfl_controller u_cpfl_controller (.ref_clk(ref_clk), .rst_n(rst_n),
        .reference_detector_input(ref_in), .feedback_detector_input(fb_in),
        .comparator_up(up), .comparator_down(down), .pump_polarity_select(pol),
        .current_offset_enable(offs), .fdet_scale_select(fsel), .wide_scale_select(wsel),
        .final_scale_select(lsel), .fdet_source(fdet_source), .fdet_sink(fdet_sink),
        .fdet_scale(fdet_scale), .loop_source(loop_source), .loop_sink(loop_sink),
        .loop_scale(loop_scale), .pump_state(pump_state), .freq_locked(freq_locked),
        .comparison_tick(comparison_tick));
    cpfl_vco_model u_cpfl_vco_model (.target_half(target), .fb_out(fb_in));

    task automatic check(input string what, input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic cycles(input int n);
        repeat (n) @(negedge ref_clk);
    endtask : cycles

    // Bounded wait for a pump state, noting every state passed on the way
    task automatic wait_state(input cpfl_state_type st, input int limit);
        seen = 3'h0;
        for (int i = 0; i < limit && pump_state !== st; i++)
        begin
            @(negedge ref_clk);
            seen = seen | pump_state;
        end
    endtask : wait_state

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : end_of_test

    initial
    begin
        #1000000;
        failures++;
        end_of_test();
    end

    initial
    begin
        cycles(3);
        check("reset_outputs", 8'({fdet_source, fdet_sink, loop_source, loop_sink}), 8'h00);
        check("reset_state", 8'(pump_state), 8'(CPFL_FDET));
        rst_n = 1'b1;
        ticks = 0;
        for (int i = 0; i < 80; i++)
        begin
            cycles(1);
            ticks += int'(comparison_tick);
        end
        check("tick_count", 8'(ticks), 8'h0a);
        up = 1'b1;
        cycles(2 * WINDOW_CORE_CYCLES);
        check("fdet_drive", 8'({fdet_source, fdet_sink}), 8'h02);
        check("loop_idle", 8'({loop_source, loop_sink, loop_scale}), 8'h00);
        for (int i = 0; i < 4; i++)
        begin
            fsel = 2'(i);
            cycles(2);
            check("fdet_scale", 8'(fdet_scale), 8'(20 * i));
        end
        fsel = 2'h1;
        pol = 1'b1;
        cycles(2);
        check("fdet_inverted", 8'({fdet_source, fdet_sink}), 8'h01);
        pol = 1'b0;
        up = 1'b0;
        $display("test detect done");

        target = 8'h28;
        wait_state(CPFL_WIDE, 3000);
        t_wide = cyc;
        check("wide_state", 8'(pump_state), 8'(CPFL_WIDE));
        check("freq_locked", 8'(freq_locked), 8'h01);
        for (int i = 1; i < 8; i++)
        begin
            wsel = 3'(i);
            cycles(2);
            check("wide_scale", 8'(loop_scale), 8'(2 * i));
        end
        check("fdet_off", 8'({fdet_source, fdet_sink, fdet_scale}), 8'h00);
        for (int k = 0; k < 4; k++)
        begin
            {pol, up} = 2'(k);
            down = ~up;
            cycles(2);
            check("loop_drive", 8'({loop_source, loop_sink}), (up ^ pol) ? 8'h02 : 8'h01);
        end
        {pol, up, down} = 3'b011;
        cycles(2);
        check("loop_both", 8'({loop_source, loop_sink}), 8'h03);
        {up, down} = 2'b00;
        $display("test wide done");

        wait_state(CPFL_FINAL, 3000);
        check("final_state", 8'(pump_state), 8'(CPFL_FINAL));
        // Final state follows the registered phase-lock verdict by one cycle
        check("window_step", 8'((cyc - t_wide) % WINDOW_CORE_CYCLES), 8'h01);
        for (int j = 0; j < 8; j++)
        begin
            {offs, lsel} = 3'(j);
            cycles(2);
            check("final_scale", 8'(loop_scale), 8'((j % 4) + 1 + (j / 4) * 4));
        end
        $display("test final done");

        // Feedback now runs faster than the reference, so detect must sink
        target = 8'h1e;
        wait_state(CPFL_FDET, 3000);
        check("relapse_state", 8'(pump_state), 8'(CPFL_FDET));
        cycles(2);
        check("relapse_drive", 8'({fdet_source, fdet_sink}), 8'h01);
        $display("test relapse done");

        wsel = 3'h0;
        target = 8'h28;
        wait_state(CPFL_FINAL, 3000);
        check("skip_state", 8'(pump_state), 8'(CPFL_FINAL));
        check("skip_no_wide", 8'(seen & CPFL_WIDE), 8'h00);
        $display("test skip done");
        end_of_test();
    end
endmodule : tb_top
`default_nettype wire
